// >>> src/cfp_regs.svh
// Constants for the fetch/execute pipeline core.
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH
`define CFP_RESET_PC 21'h0_0000
`define CFP_PC_STEP 21'h0_0002
`define CFP_PTR_STEP 21'h0_0001
`define CFP_TAIL_NIB 4'hF
`define CFP_ACC_SPLIT 8'h60
`define CFP_ACC_LO_BANK 4'h0
`define CFP_ACC_HI_BANK 4'hF
`define CFP_OP_FMOVE 4'hC
`define CFP_OP_MOVLW 8'h0E
`define CFP_OP_GOTO 8'hEF
`define CFP_OP_CALL 7'h76
`define CFP_OP_LFSR 10'h3B8
`define CFP_OP_BRA 5'h1A
`define CFP_OP_ADDWF 6'h09
`define CFP_OP_MOVWF 7'h37
`define CFP_OP_TSKIP 7'h33
`define CFP_OP_MOVLB 12'h010
`define CFP_OP_TBLRD 15'h0004
`define CFP_TBL_PTR_SEL 2'h3
`endif

// >>> src/cfp_pkg.sv
// Types shared by the fetch/execute pipeline core.
package cfp_pkg;
  typedef enum logic [3:0] {
    PH_ONE = 4'b0001,
    PH_TWO = 4'b0010,
    PH_THREE = 4'b0100,
    PH_FOUR = 4'b1000
  } cfp_phase_t;
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_JUMP = 2'h1,
    PEND_MOVE = 2'h2,
    PEND_LOAD = 2'h3
  } cfp_pend_t;
endpackage : cfp_pkg

// >>> src/cfp_core_if.sv
// Phase strobes and data-address mapping signals inside the core.
`timescale 1ns/100ps
interface cfp_core_if;
  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;
  logic access_sel;
  logic full_en;
  logic [3:0] bank_selector;
  logic [7:0] short_addr;
  logic [11:0] full_addr;
  logic [11:0] mapped_addr;
  logic [7:0] raw_rdata;
  logic present;
  logic [7:0] clean_rdata;
  modport phase_src (
    output phase_one, phase_two, phase_three, phase_four
  );
  modport mapper (
    input access_sel, full_en, bank_selector, short_addr, full_addr,
    input raw_rdata, present,
    output mapped_addr, clean_rdata
  );
  modport core (
    input phase_one, phase_two, phase_three, phase_four,
    input mapped_addr, clean_rdata,
    output access_sel, full_en, bank_selector, short_addr, full_addr,
    output raw_rdata, present
  );
endinterface : cfp_core_if

// >>> src/cfp_phase_gen.sv
// Four-phase sequencer dividing the core clock.
`timescale 1ns/100ps
module cfp_phase_gen (
  input logic ref_clk,
  input logic resetn,
  input logic clk_en,
  cfp_core_if.phase_src ph
);
  import cfp_pkg::*;

  cfp_phase_t state_q;
  cfp_phase_t state_d;

  always_comb
  begin
    unique case (state_q)
      PH_ONE: state_d = PH_TWO;
      PH_TWO: state_d = PH_THREE;
      PH_THREE: state_d = PH_FOUR;
      PH_FOUR: state_d = PH_ONE;
      default: state_d = PH_ONE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= PH_ONE;
    else if (clk_en)
      state_q <= state_d;
  end

  assign ph.phase_one = state_q == PH_ONE;
  assign ph.phase_two = state_q == PH_TWO;
  assign ph.phase_three = state_q == PH_THREE;
  assign ph.phase_four = state_q == PH_FOUR;

  property p_phase_cycle;
    @(posedge ref_clk) disable iff (!resetn)
    (state_q == PH_ONE) && clk_en ##1 clk_en[*3] |->
      state_q == PH_FOUR ##1 state_q == PH_ONE;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle)
    else $error("phase sequence is not one-two-three-four");

endmodule : cfp_phase_gen

// >>> src/cfp_data_map.sv
// Data-memory address former and unimplemented-read filter.
`timescale 1ns/100ps
`include "cfp_regs.svh"
module cfp_data_map (
  cfp_core_if.mapper mp
);
  import cfp_pkg::*;

  logic low_half;
  logic [3:0] fast_bank;
  logic [3:0] bank;

  // The fast space is one contiguous 8-bit map over two physical banks.
  assign low_half = mp.short_addr < `CFP_ACC_SPLIT;
  assign fast_bank = low_half ? `CFP_ACC_LO_BANK : `CFP_ACC_HI_BANK;
  assign bank = mp.access_sel ? mp.bank_selector : fast_bank;
  assign mp.mapped_addr = mp.full_en ? mp.full_addr
                                     : {bank, mp.short_addr};
  assign mp.clean_rdata = mp.present ? mp.raw_rdata : 8'h00;

endmodule : cfp_data_map

// >>> src/cfp_core.sv
// Fetch/execute pipeline core with quadrature phase sequencing.
`timescale 1ns/100ps
`include "cfp_regs.svh"
module cfp_core (
  input logic ref_clk,
  input logic resetn,
  input logic clk_en,
  output logic [20:0] pm_addr,
  input logic [15:0] pm_rdata,
  output logic [20:0] tbl_addr,
  input logic [15:0] tbl_rdata,
  output logic [11:0] dm_addr,
  output logic dm_rd_en,
  output logic dm_wr_en,
  output logic [7:0] dm_wdata,
  input logic [7:0] dm_rdata,
  input logic dm_present,
  output logic [20:0] pc,
  output logic [7:0] wreg,
  output logic [3:0] bank_selector,
  output logic [20:0] table_byte_pointer,
  output logic [7:0] table_data_latch,
  output logic [11:0] indirect_ptr,
  output cfp_pkg::cfp_pend_t pend_state
);
  import cfp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Sub-blocks.

  cfp_core_if bus ();

  cfp_phase_gen u_phase (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .ph(bus.phase_src)
  );

  cfp_data_map u_map (
    .mp(bus.mapper)
  );

  //////////////////////////////////////////////////////////////////////////
  // State.

  logic [20:0] pc_q;
  logic [20:0] pc_d;
  logic [20:0] fetch_addr_q;
  logic [15:0] fetched_q;
  logic fetched_valid_q;
  logic [15:0] ir_q;
  logic ir_valid_q;
  cfp_pend_t pend_q;
  cfp_pend_t pend_d;
  logic [7:0] lo_q;
  logic [7:0] opnd_q;
  logic [7:0] wreg_q;
  logic [7:0] wreg_d;
  logic [3:0] bsel_q;
  logic [20:0] tptr_q;
  logic [20:0] tptr_d;
  logic [7:0] tlat_q;
  logic [11:0] iptr_q;
  logic [11:0] dm_addr_q;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;

  logic p1;
  logic p2;
  logic p3;
  logic p4;
  assign p1 = bus.phase_one && clk_en;
  assign p2 = bus.phase_two && clk_en;
  assign p3 = bus.phase_three && clk_en;
  assign p4 = bus.phase_four && clk_en;

  //////////////////////////////////////////////////////////////////////////
  // Decode of the word in the instruction register.

  logic second_w;
  logic first_w;
  logic tail_w;
  logic lone_tail_w;
  logic movlw_w;
  logic movlb_w;
  logic addwf_w;
  logic movwf_w;
  logic tskip_w;
  logic fmove1_w;
  logic jump1_w;
  logic lfsr1_w;
  logic bra_w;
  logic tblrd_w;
  logic jump2_w;
  logic move2_w;
  logic load2_w;
  logic reads_w;
  logic writes_w;
  logic skip_w;
  logic take_w;
  logic flush_w;
  logic [7:0] sum_w;
  logic [20:0] bra_disp_w;
  logic [20:0] branch_pc_w;
  logic [7:0] tbl_byte_w;

  assign second_w = pend_q != PEND_NONE;
  assign first_w = ir_valid_q && !second_w;
  assign tail_w = ir_q[15:12] == `CFP_TAIL_NIB;
  // A tail reached without its first word does nothing at all.
  assign lone_tail_w = first_w && tail_w;
  assign movlw_w = first_w && ir_q[15:8] == `CFP_OP_MOVLW;
  assign movlb_w = first_w && ir_q[15:4] == `CFP_OP_MOVLB;
  assign addwf_w = first_w && ir_q[15:10] == `CFP_OP_ADDWF;
  assign movwf_w = first_w && ir_q[15:9] == `CFP_OP_MOVWF;
  assign tskip_w = first_w && ir_q[15:9] == `CFP_OP_TSKIP;
  assign fmove1_w = first_w && ir_q[15:12] == `CFP_OP_FMOVE;
  assign jump1_w = first_w && (ir_q[15:8] == `CFP_OP_GOTO ||
                               ir_q[15:9] == `CFP_OP_CALL);
  assign lfsr1_w = first_w && ir_q[15:6] == `CFP_OP_LFSR;
  assign bra_w = first_w && ir_q[15:11] == `CFP_OP_BRA;
  assign tblrd_w = first_w && ir_q[15:1] == `CFP_OP_TBLRD;
  assign jump2_w = ir_valid_q && pend_q == PEND_JUMP && tail_w;
  assign move2_w = ir_valid_q && pend_q == PEND_MOVE && tail_w;
  assign load2_w = ir_valid_q && pend_q == PEND_LOAD && tail_w;

  assign reads_w = addwf_w || tskip_w || fmove1_w;
  assign writes_w = movwf_w || (addwf_w && ir_q[9]) || move2_w;
  assign sum_w = wreg_q + opnd_q;

  // Offset counts words, so the byte displacement is doubled.
  assign bra_disp_w = {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
  // The word address lands on bits 20..1; bit 0 stays clear.
  assign branch_pc_w = bra_w ? fetch_addr_q + bra_disp_w
                             : {ir_q[11:0], lo_q, 1'b0};
  assign skip_w = tskip_w && opnd_q == 8'h00;
  assign take_w = bra_w || jump2_w;
  assign flush_w = take_w || skip_w;

  //////////////////////////////////////////////////////////////////////////
  // Data-memory side.

  // The address is formed from the word entering the instruction
  // register, so it is already steady when phase two reads.
  assign bus.access_sel = fetched_q[8];
  assign bus.full_en = pend_q == PEND_MOVE ||
    (pend_q == PEND_NONE && fetched_q[15:12] == `CFP_OP_FMOVE);
  assign bus.bank_selector = bsel_q;
  assign bus.short_addr = fetched_q[7:0];
  assign bus.full_addr = fetched_q[11:0];
  assign bus.raw_rdata = dm_rdata;
  assign bus.present = dm_present;

  assign dm_rd_en = bus.phase_two && reads_w;
  assign dm_wr_en = bus.phase_four && writes_w;
  assign wdata_d = movwf_w ? wreg_q : (addwf_w ? sum_w : opnd_q);

  //////////////////////////////////////////////////////////////////////////
  // Next values.

  assign pc_d = (p4 && take_w) ? branch_pc_w
              : p1 ? pc_q + `CFP_PC_STEP : pc_q;
  assign pend_d = fmove1_w ? PEND_MOVE
                : jump1_w ? PEND_JUMP
                : lfsr1_w ? PEND_LOAD : PEND_NONE;
  assign wreg_d = movlw_w ? ir_q[7:0]
                : (addwf_w && !ir_q[9]) ? sum_w : wreg_q;
  // Two bytes per program word: the pointer's bit 0 picks the half.
  assign tbl_byte_w = tptr_q[0] ? tbl_rdata[15:8] : tbl_rdata[7:0];
  assign tptr_d = (load2_w && lo_q[5:4] == `CFP_TBL_PTR_SEL)
                ? {9'h000, lo_q[3:0], ir_q[7:0]}
                : (tblrd_w && ir_q[0]) ? tptr_q + `CFP_PTR_STEP : tptr_q;

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pc_q <= `CFP_RESET_PC;
    else
      pc_q <= pc_d;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_addr_q <= `CFP_RESET_PC;
      ir_q <= 16'h0000;
      ir_valid_q <= 1'b0;
      dm_addr_q <= 12'h000;
    end
    else if (p1)
    begin
      fetch_addr_q <= pc_q;
      ir_q <= fetched_q;
      ir_valid_q <= fetched_valid_q;
      dm_addr_q <= bus.mapped_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      opnd_q <= 8'h00;
    else if (p2 && reads_w)
      opnd_q <= bus.clean_rdata;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      wdata_q <= 8'h00;
    else if (p3)
      wdata_q <= wdata_d;
  end

  // Fetch of the next word shares phase four with the current execute.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetched_q <= 16'h0000;
      fetched_valid_q <= 1'b0;
      pend_q <= PEND_NONE;
      lo_q <= 8'h00;
    end
    else if (p4)
    begin
      fetched_q <= pm_rdata;
      fetched_valid_q <= !flush_w;
      pend_q <= pend_d;
      lo_q <= ir_q[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wreg_q <= 8'h00;
      bsel_q <= 4'h0;
      tptr_q <= `CFP_RESET_PC;
      tlat_q <= 8'h00;
      iptr_q <= 12'h000;
    end
    else if (p4)
    begin
      wreg_q <= wreg_d;
      if (movlb_w)
        bsel_q <= ir_q[3:0];
      tptr_q <= tptr_d;
      if (tblrd_w)
        tlat_q <= tbl_byte_w;
      if (load2_w && lo_q[5:4] != `CFP_TBL_PTR_SEL)
        iptr_q <= {lo_q[3:0], ir_q[7:0]};
    end
  end

  assign pm_addr = fetch_addr_q;
  assign tbl_addr = {tptr_q[20:1], 1'b0};
  assign dm_addr = dm_addr_q;
  assign dm_wdata = wdata_q;
  assign pc = pc_q;
  assign wreg = wreg_q;
  assign bank_selector = bsel_q;
  assign table_byte_pointer = tptr_q;
  assign table_data_latch = tlat_q;
  assign indirect_ptr = iptr_q;
  assign pend_state = pend_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_pc_step;
    @(posedge ref_clk) disable iff (!resetn)
    p1 |=> pc_q == $past(pc_q) + `CFP_PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter did not step by two in phase one");

  property p_pc_even;
    @(posedge ref_clk) disable iff (!resetn)
    !pc_q[0] && !fetch_addr_q[0];
  endproperty
  a_pc_even: assert property (p_pc_even)
    else $error("program counter bit zero is set");

  property p_rd_phase;
    @(posedge ref_clk) disable iff (!resetn)
    dm_rd_en |-> bus.phase_two && ir_valid_q;
  endproperty
  a_rd_phase: assert property (p_rd_phase)
    else $error("data read outside phase two");

  property p_wr_phase;
    @(posedge ref_clk) disable iff (!resetn)
    p3 && writes_w |=> dm_wr_en && dm_wdata == $past(wdata_d);
  endproperty
  a_wr_phase: assert property (p_wr_phase)
    else $error("destination write missing in phase four");

  property p_exec_after_fetch;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(ir_valid_q) |-> $past(fetched_valid_q) && $past(p1);
  endproperty
  a_exec_after_fetch: assert property (p_exec_after_fetch)
    else $error("execution began without a completed fetch");

  property p_flush;
    @(posedge ref_clk) disable iff (!resetn)
    p4 && take_w |=> !fetched_valid_q ##0 pc_q == $past(branch_pc_w)
      ##4 (!ir_valid_q || !clk_en);
  endproperty
  a_flush: assert property (p_flush)
    else $error("prefetched word not discarded on branch");

  property p_jump_target;
    @(posedge ref_clk) disable iff (!resetn)
    p4 && jump2_w |=> pc_q == {$past(ir_q[11:0]), $past(lo_q), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("absolute jump target wrong");

  property p_lone_tail;
    @(posedge ref_clk) disable iff (!resetn)
    p4 && lone_tail_w |=> wreg_q == $past(wreg_q) &&
      fetched_valid_q && pend_q == PEND_NONE && !$past(dm_wr_en);
  endproperty
  a_lone_tail: assert property (p_lone_tail)
    else $error("lone tail word had an effect");

  property p_unimpl_zero;
    @(posedge ref_clk) disable iff (!resetn)
    p2 && reads_w && !dm_present |=> opnd_q == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented location did not read zero");

endmodule : cfp_core

// >>> test/cfp_mem_model.sv
// Program and data memory arrays facing the pipeline core.
`timescale 1ns/100ps
module cfp_mem_model (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic [20:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire logic [20:0] tbl_addr,
  output logic [15:0] tbl_rdata,
  input wire logic [11:0] dm_addr,
  input wire logic dm_wr_en,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  output logic dm_present
);
  logic [15:0] prog [0:1023];
  logic [7:0] data [0:4095];
  logic flip_q = 1'b0;
  logic impl;
  // Banks 8 to 14 are absent so that the core's zero fill can be seen.
  assign impl = (dm_addr < 12'h800) || (dm_addr[11:8] == 4'hF);
  assign dm_present = impl;
  // An absent location floats; a value that flips each cycle stands for it.
  assign dm_rdata = impl ? data[dm_addr] : (flip_q ? 8'h5A : 8'hA5);
  assign pm_rdata = prog[pm_addr[10:1]];
  assign tbl_rdata = prog[tbl_addr[10:1]];
  always @(posedge ref_clk)
  begin
    flip_q <= ~flip_q;
    if (clk_en && dm_wr_en && impl)
      data[dm_addr] <= dm_wdata;
  end
endmodule : cfp_mem_model

// >>> test/cfp_core_tb.sv
// Self-checking bench for the fetch/execute pipeline core.
`timescale 1ns/100ps
module cfp_core_tb;
  import cfp_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [20:0] pm_addr, tbl_addr, pc, table_byte_pointer;
  logic [15:0] pm_rdata, tbl_rdata;
  logic [11:0] dm_addr, indirect_ptr;
  logic dm_rd_en, dm_wr_en, dm_present;
  logic [7:0] dm_wdata, dm_rdata, wreg, table_data_latch;
  logic [3:0] bank_selector;
  cfp_pend_t pend_state;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int run_cyc = 0;
  logic bad_seen = 1'b0;

  always #5 ref_clk = ~ref_clk;

  cfp_core cfp_core_i (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .tbl_addr(tbl_addr),
    .tbl_rdata(tbl_rdata), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
    .dm_wr_en(dm_wr_en), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .dm_present(dm_present), .pc(pc), .wreg(wreg),
    .bank_selector(bank_selector), .table_byte_pointer(table_byte_pointer),
    .table_data_latch(table_data_latch), .indirect_ptr(indirect_ptr),
    .pend_state(pend_state));

  cfp_mem_model cfp_mem_model_i (.ref_clk(ref_clk), .clk_en(clk_en),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .tbl_addr(tbl_addr),
    .tbl_rdata(tbl_rdata), .dm_addr(dm_addr), .dm_wr_en(dm_wr_en),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_present(dm_present));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got,
        exp);
    end
  endtask : check_val

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // The bench counts enabled edges itself, so phase one is a count of 0.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cyc <= 0;
    else if (clk_en)
      cyc <= cyc + 1;
  end

  always @(negedge ref_clk)
  begin
    if (resetn && dm_rd_en === 1'b1)
      check_val(cyc % 4, 1, "read strobe phase");
    if (resetn && dm_wr_en === 1'b1)
      check_val(cyc % 4, 3, "write strobe phase");
    if (wreg === 8'h11)
      bad_seen = 1'b1;
  end

  always @(posedge ref_clk)
  begin
    run_cyc++;
    if (run_cyc == 3000)
    begin
      num_errors++;
      $display("ERROR at %0t: run took too long", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory is cleared under reset so that unused words decode as no-ops.
  task automatic start(input logic [15:0] w [$]);
    @(negedge ref_clk);
    resetn = 1'b0;
    bad_seen = 1'b0;
    for (int i = 0; i < 1024; i++)
      cfp_mem_model_i.prog[i] = (i < w.size()) ? w[i] : 16'h0000;
    for (int i = 0; i < 4096; i++)
      cfp_mem_model_i.data[i] = 8'h00;
    repeat (6) @(negedge ref_clk);
  endtask : start

  // Instruction n finishes at the edge 8 + 4n after release.
  task automatic run(input int n);
    resetn = 1'b1;
    repeat (4 * n + 4) @(negedge ref_clk);
  endtask : run

  task automatic t_phase;
    start('{16'h0E5A});
    check_val(pend_state, PEND_NONE, "pending after reset");
    resetn = 1'b1;
    @(negedge ref_clk);
    check_val(pc, 21'h00_0002, "pc after first edge");
    check_val(pm_addr, 21'h00_0000, "first fetch address");
    repeat (4) @(negedge ref_clk);
    check_val(pc, 21'h00_0004, "pc after one cycle");
    check_val(pm_addr, 21'h00_0002, "second fetch address");
    check_val(wreg, 8'h00, "before execute");
    clk_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    check_val(pc, 21'h00_0004, "pc while frozen");
    clk_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_val(pc, 21'h00_0006, "pc after resume");
    check_val(wreg, 8'h5A, "first execute");
    $display("test phase done");
  endtask : t_phase

  task automatic t_access;
    start('{16'h0E55, 16'h6E10, 16'h6E70, 16'h0103, 16'h6F20, 16'h2410,
      16'h0109, 16'h2501});
    run(8);
    check_val(cfp_mem_model_i.data[12'h010], 8'h55, "low fast");
    check_val(cfp_mem_model_i.data[12'hF70], 8'h55, "high fast");
    check_val(cfp_mem_model_i.data[12'h070], 8'h00, "bank zero");
    check_val(cfp_mem_model_i.data[12'h320], 8'h55, "banked");
    check_val(cfp_mem_model_i.data[12'h020], 8'h00, "no fast");
    check_val(bank_selector, 4'h9, "bank selector");
    check_val(wreg, 8'hAA, "sum with absent read");
    $display("test access done");
  endtask : t_access

  task automatic t_jump;
    start('{16'hEF10, 16'hF001, 16'h0E11, 16'h0E11});
    cfp_mem_model_i.prog[272] = 16'hD003;
    for (int i = 273; i < 276; i++)
      cfp_mem_model_i.prog[i] = 16'h0E11;
    cfp_mem_model_i.prog[276] = 16'h0E33;
    run(1);
    check_val(pend_state, PEND_JUMP, "jump tail pending");
    run(10);
    check_val(wreg, 8'h33, "branch target");
    check_val(bad_seen, 1'b0, "flushed word ran");
    $display("test jump done");
  endtask : t_jump

  task automatic t_skip;
    start('{16'h6605, 16'hC010, 16'hF020, 16'h6606, 16'hC010, 16'hF030,
      16'h0E44});
    cfp_mem_model_i.data[6] = 8'h01;
    cfp_mem_model_i.data[16] = 8'h77;
    cfp_mem_model_i.data[32] = 8'hA5;
    run(12);
    check_val(cfp_mem_model_i.data[32], 8'hA5, "lone tail");
    check_val(cfp_mem_model_i.data[48], 8'h77, "full move");
    check_val(wreg, 8'h44, "after moves");
    $display("test skip done");
  endtask : t_skip

  task automatic t_table;
    start('{16'hEE31, 16'hF001, 16'h0009, 16'h0008, 16'hEE01, 16'hF023});
    cfp_mem_model_i.prog[128] = 16'hBEEF;
    cfp_mem_model_i.prog[129] = 16'hCAFE;
    run(3);
    check_val(table_data_latch, 8'hBE, "odd byte");
    run(6);
    check_val(table_data_latch, 8'hFE, "table byte");
    check_val(table_byte_pointer, 21'h00_0102, "table pointer");
    check_val(indirect_ptr, 12'h123, "indirect pointer");
    $display("test table done");
  endtask : t_table

  initial
  begin
    t_phase();
    t_access();
    t_jump();
    t_skip();
    t_table();
    end_sim();
  end
endmodule : cfp_core_tb
